// ===== src/aice_exec.v
/*
  Accumulator transfer and interrupt command executor. Receives nine-byte
  command frames as a byte stream, executes the accumulator, flag and
  interrupt commands, dispatches interrupts to stored vectors and sends
  nine-byte replies. Assumes a single 50 MHz clock, inputs synchronous to it,
  and a program sequencer that supplies PC_IN and follows PC_LOAD.
*/
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`include "aice_consts.vh"

module aice_exec (
  input wire MCLK,
  input wire RST,
  input wire RX_VALID,
  input wire [7:0] RX_BYTE,
  output wire RX_READY,
  output reg TX_VALID,
  output reg [7:0] TX_BYTE,
  input wire [4:0] ERR_SET,
  input wire [31:0] IRQ_REQ,
  input wire [31:0] PC_IN,
  output reg PC_LOAD,
  output reg [31:0] PC_VALUE,
  output reg IN_HANDLER,
  output reg AXP_WE,
  output reg [7:0] AXP_INDEX,
  output reg [7:0] AXP_MOTOR,
  output reg [31:0] AXP_DATA,
  output reg GLP_WE,
  output reg [7:0] GLP_INDEX,
  output reg [7:0] GLP_BANK,
  output reg [31:0] GLP_DATA,
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA
);

  // =====================================================
  // State
  reg [7:0] frame [0:8];
  reg [3:0] rx_cnt;
  reg frame_done;
  reg [7:0] reply [0:8];
  reg [3:0] tx_cnt;
  reg tx_busy;
  reg [31:0] accu;
  reg [31:0] xreg;
  reg [4:0] flags;
  reg [31:0] irq_en;
  reg global_en;
  reg [31:0] irq_vector_define_cmd [0:31];
  reg [31:0] save_accu;
  reg [31:0] save_xreg;
  reg [4:0] save_flags;
  reg [31:0] save_pc;
  reg [7:0] mod_addr;
  reg [7:0] host_addr;
  reg [4:0] vsel;
  reg [4:0] next_flags;
  reg [31:0] next_irq_en;
  reg [7:0] next_status;
  reg [4:0] irq_num;
  reg irq_hit;
  integer i;
  integer j, k, m;

  wire [31:0] fr_value = {frame[4], frame[5], frame[6], frame[7]};
  wire [7:0] fr_cmd = frame[1];
  wire [7:0] fr_type = frame[2];
  wire [7:0] fr_bank = frame[3];
  wire [31:0] irq_live = IRQ_REQ & irq_en;
  wire [7:0] sum_all = byte_sum(frame[0], frame[1], frame[2], frame[3], frame[4],
                                frame[5], frame[6], frame[7]);
  wire sum_ok = (sum_all == frame[8]);
  wire do_exec = frame_done && sum_ok && (frame[0] == mod_addr);
  wire is_ours = (fr_cmd == `AICE_CMD_IRQ_ENABLE) || (fr_cmd == `AICE_CMD_IRQ_DISABLE) ||
                 (fr_cmd == `AICE_CMD_ACCU_TO_AXIS) || (fr_cmd == `AICE_CMD_ACCU_TO_GLOBAL) ||
                 (fr_cmd == `AICE_CMD_CLEAR_FLAGS) || (fr_cmd == `AICE_CMD_IRQ_VECTOR) ||
                 (fr_cmd == `AICE_CMD_IRQ_RETURN);
  wire is_irq_return_cmd = do_exec && (fr_cmd == `AICE_CMD_IRQ_RETURN) && IN_HANDLER;
  wire dispatch = irq_hit && global_en && !IN_HANDLER && !is_irq_return_cmd;

  assign RX_READY = !tx_busy;

  // Modulo-256 sum of eight bytes
  function [7:0] byte_sum;
    input [7:0] b0, b1, b2, b3, b4, b5, b6, b7;
    begin
      byte_sum = b0 + b1 + b2 + b3 + b4 + b5 + b6 + b7;
    end
  endfunction

  // =====================================================
  // Lowest enabled pending interrupt
  always @* begin
    irq_hit = 1'b0;
    irq_num = 5'h0_0;
    for (i = 31; i >= 0; i = i - 1) begin
      if (irq_live[i]) begin
        irq_hit = 1'b1;
        irq_num = i[4:0];
      end
    end
  end

  // =====================================================
  // Frame assembly: address, code, type, bank, value MSB first, checksum
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rx_cnt <= 4'h0;
      frame_done <= 1'b0;
      for (j = 0; j < 9; j = j + 1) begin
        frame[j] <= 8'h0_0;
      end
    end else begin
      frame_done <= 1'b0;
      if (RX_VALID && !tx_busy) begin
        frame[rx_cnt] <= RX_BYTE;
        if (rx_cnt == `AICE_FRAME_LAST) begin
          rx_cnt <= 4'h0;
          frame_done <= 1'b1;
        end else begin
          rx_cnt <= rx_cnt + 4'h1;
        end
      end
    end
  end

  // =====================================================
  // Flag and enable updates
  always @* begin
    next_flags = flags;
    next_irq_en = irq_en;
    if (do_exec && fr_cmd == `AICE_CMD_CLEAR_FLAGS) begin
      case (fr_type)
        8'h0_0: next_flags = 5'h0_0;
        8'h0_1: next_flags[`AICE_F_TIMEOUT] = 1'b0;
        8'h0_2: next_flags[`AICE_F_ALARM] = 1'b0;
        8'h0_3: next_flags[`AICE_F_DEVIATION] = 1'b0;
        8'h0_4: next_flags[`AICE_F_POSITION] = 1'b0;
        8'h0_5: next_flags[`AICE_F_SHUTDOWN] = 1'b0;
        default: next_flags = flags;
      endcase
    end
    if (is_irq_return_cmd) begin
      next_flags = save_flags;
    end
    next_flags = next_flags | ERR_SET;
    if (do_exec && fr_type[7:5] == 3'h0) begin
      if (fr_cmd == `AICE_CMD_IRQ_ENABLE) begin
        next_irq_en[fr_type[4:0]] = 1'b1;
      end else if (fr_cmd == `AICE_CMD_IRQ_DISABLE) begin
        next_irq_en[fr_type[4:0]] = 1'b0;
      end
    end
    if (!frame_done) begin
      next_status = `AICE_ST_OK;
    end else if (!sum_ok) begin
      next_status = `AICE_ST_BAD_SUM;
    end else if (!is_ours) begin
      next_status = `AICE_ST_BAD_CMD;
    end else begin
      next_status = `AICE_ST_OK;
    end
  end

  // =====================================================
  // Command execution and interrupt dispatch
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      accu <= 32'h0000_0000;
      xreg <= 32'h0000_0000;
      flags <= 5'h0_0;
      irq_en <= 32'h0000_0000;
      global_en <= 1'b0;
      save_accu <= 32'h0000_0000;
      save_xreg <= 32'h0000_0000;
      save_flags <= 5'h0_0;
      save_pc <= 32'h0000_0000;
      IN_HANDLER <= 1'b0;
      PC_LOAD <= 1'b0;
      PC_VALUE <= 32'h0000_0000;
      AXP_WE <= 1'b0;
      AXP_INDEX <= 8'h0_0;
      AXP_MOTOR <= 8'h0_0;
      AXP_DATA <= 32'h0000_0000;
      GLP_WE <= 1'b0;
      GLP_INDEX <= 8'h0_0;
      GLP_BANK <= 8'h0_0;
      GLP_DATA <= 32'h0000_0000;
      mod_addr <= `AICE_RST_MOD_ADDR;
      host_addr <= `AICE_RST_HOST_ADDR;
      vsel <= 5'h0_0;
      for (k = 0; k < 32; k = k + 1) begin
        irq_vector_define_cmd[k] <= 32'h0000_0000;
      end
    end else begin
      AXP_WE <= 1'b0;
      GLP_WE <= 1'b0;
      PC_LOAD <= 1'b0;
      flags <= next_flags;
      irq_en <= next_irq_en;
      if (WR) begin
        case (ADDR)
          `AICE_REG_ACCU: accu <= WDATA;
          `AICE_REG_XREG: xreg <= WDATA;
          `AICE_REG_CTRL: begin
            global_en <= WDATA[0];
            mod_addr <= WDATA[15:8];
            host_addr <= WDATA[23:16];
          end
          `AICE_REG_VSEL: vsel <= WDATA[4:0];
          default: vsel <= vsel;
        endcase
      end
      if (do_exec && frame[0] == mod_addr) begin
        case (fr_cmd)
          `AICE_CMD_ACCU_TO_AXIS: begin
            AXP_WE <= 1'b1;
            AXP_INDEX <= fr_type;
            AXP_MOTOR <= fr_bank;
            AXP_DATA <= accu;
          end
          `AICE_CMD_ACCU_TO_GLOBAL: begin
            if (fr_bank == 8'h0_0 || fr_bank == 8'h0_2 || fr_bank == 8'h0_3) begin
              GLP_WE <= 1'b1;
              GLP_INDEX <= fr_type;
              GLP_BANK <= fr_bank;
              GLP_DATA <= accu;
            end
          end
          `AICE_CMD_IRQ_ENABLE: begin
            if (fr_type == `AICE_IRQ_GLOBAL) begin
              global_en <= 1'b1;
            end
          end
          `AICE_CMD_IRQ_DISABLE: begin
            if (fr_type == `AICE_IRQ_GLOBAL) begin
              global_en <= 1'b0;
            end
          end
          `AICE_CMD_IRQ_VECTOR: begin
            if (fr_type[7:5] == 3'h0) begin
              irq_vector_define_cmd[fr_type[4:0]] <= fr_value;
            end
          end
          `AICE_CMD_IRQ_RETURN: begin
            if (IN_HANDLER) begin
              accu <= save_accu;
              xreg <= save_xreg;
              PC_VALUE <= save_pc;
              PC_LOAD <= 1'b1;
              IN_HANDLER <= 1'b0;
            end
          end
          default: IN_HANDLER <= IN_HANDLER;
        endcase
      end
      if (dispatch) begin
        save_accu <= accu;
        save_xreg <= xreg;
        save_flags <= flags;
        save_pc <= PC_IN;
        PC_VALUE <= irq_vector_define_cmd[irq_num];
        PC_LOAD <= 1'b1;
        IN_HANDLER <= 1'b1;
      end
    end
  end

  // =====================================================
  // Reply sender: host, target, status, code, value MSB first, checksum
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      tx_busy <= 1'b0;
      tx_cnt <= 4'h0;
      TX_VALID <= 1'b0;
      TX_BYTE <= 8'h0_0;
      for (m = 0; m < 9; m = m + 1) begin
        reply[m] <= 8'h0_0;
      end
    end else begin
      TX_VALID <= 1'b0;
      if (frame_done && frame[0] == mod_addr) begin
        tx_busy <= 1'b1;
        tx_cnt <= 4'h0;
        reply[0] <= host_addr;
        reply[1] <= mod_addr;
        reply[2] <= next_status;
        reply[3] <= fr_cmd;
        reply[4] <= 8'h0_0;
        reply[5] <= 8'h0_0;
        reply[6] <= 8'h0_0;
        reply[7] <= 8'h0_0;
        reply[8] <= byte_sum(host_addr, mod_addr, next_status, fr_cmd,
                             8'h0_0, 8'h0_0, 8'h0_0, 8'h0_0);
      end else if (tx_busy) begin
        TX_VALID <= 1'b1;
        TX_BYTE <= reply[tx_cnt];
        if (tx_cnt == `AICE_FRAME_LAST) begin
          tx_busy <= 1'b0;
        end else begin
          tx_cnt <= tx_cnt + 4'h1;
        end
      end
    end
  end

  // =====================================================
  // Register read port, data one cycle after the strobe
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      case (ADDR)
        `AICE_REG_ACCU: RDATA <= accu;
        `AICE_REG_XREG: RDATA <= xreg;
        `AICE_REG_FLAGS: RDATA <= {27'h0, flags};
        `AICE_REG_IRQ_EN: RDATA <= irq_en;
        `AICE_REG_CTRL: RDATA <= {8'h0_0, host_addr, mod_addr, 7'h0_0, global_en};
        `AICE_REG_VSEL: RDATA <= {27'h0, vsel};
        `AICE_REG_VDATA: RDATA <= irq_vector_define_cmd[vsel];
        `AICE_REG_STATE: RDATA <= {30'h0, tx_busy, IN_HANDLER};
        default: RDATA <= 32'h0000_0000;
      endcase
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

endmodule

// ===== src/aice_consts.vh
/*
  Constants of the accumulator and interrupt command executor: command codes,
  frame layout, reply status codes, register offsets and reset values.
  Assumes inclusion by bare name from the executor module.

*/
`ifndef AICE_CONSTS_VH
`define AICE_CONSTS_VH

// =====================================================
// Command codes
`define AICE_CMD_IRQ_ENABLE 8'h19
`define AICE_CMD_IRQ_DISABLE 8'h1A
`define AICE_CMD_ACCU_TO_AXIS 8'h22
`define AICE_CMD_ACCU_TO_GLOBAL 8'h23
`define AICE_CMD_CLEAR_FLAGS 8'h24
`define AICE_CMD_IRQ_VECTOR 8'h25
`define AICE_CMD_IRQ_RETURN 8'h26
`define AICE_IRQ_GLOBAL 8'hFF

// =====================================================
// Frame layout and reply
`define AICE_FRAME_LEN 4'h9
`define AICE_FRAME_LAST 4'h8
`define AICE_ST_OK 8'h64
`define AICE_ST_BAD_SUM 8'h01
`define AICE_ST_BAD_CMD 8'h02

// =====================================================
// Error flag positions
`define AICE_F_TIMEOUT 0
`define AICE_F_ALARM 1
`define AICE_F_DEVIATION 2
`define AICE_F_POSITION 3
`define AICE_F_SHUTDOWN 4

// =====================================================
// Register offsets
`define AICE_REG_ACCU 8'h00
`define AICE_REG_XREG 8'h04
`define AICE_REG_FLAGS 8'h08
`define AICE_REG_IRQ_EN 8'h0C
`define AICE_REG_CTRL 8'h10
`define AICE_REG_VSEL 8'h14
`define AICE_REG_VDATA 8'h18
`define AICE_REG_STATE 8'h1C

// =====================================================
// Reset values
`define AICE_RST_MOD_ADDR 8'h01
`define AICE_RST_HOST_ADDR 8'h02

`endif

// ===== sim/aice_exec_asserts.sv
/* Port checker of the command executor.
   Assumes binding to aice_exec, default addresses kept. */
`timescale 1ns/1ns
`include "aice_consts.vh"
module aice_exec_asserts (
  input wire MCLK,
  input wire RST,
  input wire RX_READY,
  input wire TX_VALID,
  input wire [7:0] TX_BYTE,
  input wire PC_LOAD,
  input wire IN_HANDLER,
  input wire AXP_WE,
  input wire GLP_WE,
  input wire [7:0] GLP_BANK
);
  // ==========================================
  // Port relations
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  chk_axp_reply: assert property (AXP_WE |=> TX_VALID)
    else $error("no reply after axis write");
  chk_glp_reply: assert property (GLP_WE |=> TX_VALID)
    else $error("no reply after global write");
  chk_tx_burst: assert property ($rose(TX_VALID) |-> TX_VALID[*8] ##1 TX_VALID ##1 !TX_VALID)
    else $error("reply not nine bytes");
  chk_reply_head: assert property ($rose(TX_VALID) |-> TX_BYTE == `AICE_RST_HOST_ADDR ##1
    TX_BYTE == `AICE_RST_MOD_ADDR ##1 (TX_BYTE == `AICE_ST_OK ||
    TX_BYTE == `AICE_ST_BAD_SUM || TX_BYTE == `AICE_ST_BAD_CMD))
    else $error("reply header wrong");
  chk_busy_ready: assert property ($rose(TX_VALID) |->
    (!RX_READY)[*8] ##1 RX_READY)
    else $error("ready while replying");
  chk_exec_busy: assert property (AXP_WE || GLP_WE |-> !RX_READY)
    else $error("ready while executing");
  chk_glp_bank: assert property (GLP_WE |-> GLP_BANK == 8'h00 || GLP_BANK == 8'h02 ||
    GLP_BANK == 8'h03)
    else $error("global write to bad bank");
  chk_dispatch_jump: assert property ($rose(IN_HANDLER) |-> PC_LOAD)
    else $error("handler entry without jump");
  chk_return_jump: assert property ($fell(IN_HANDLER) |-> PC_LOAD)
    else $error("handler exit without jump");
endmodule
bind aice_exec aice_exec_asserts chk_u (.MCLK(MCLK), .RST(RST), .RX_READY(RX_READY),
  .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .PC_LOAD(PC_LOAD), .IN_HANDLER(IN_HANDLER),
  .AXP_WE(AXP_WE), .GLP_WE(GLP_WE), .GLP_BANK(GLP_BANK));

// ===== sim/aice_host.sv
/* Host model: sends command frames, gathers reply bytes.
   Assumes the executor byte stream on one clock. */
`timescale 1ns/1ns
module aice_host (
  input wire MCLK,
  input wire RX_READY,
  input wire TX_VALID,
  input wire [7:0] TX_BYTE,
  output reg RX_VALID,
  output reg [7:0] RX_BYTE
);
  reg [7:0] f [0:8];
  reg [7:0] rep [0:8];
  integer n;
  integer i;
  initial begin
    RX_VALID = 1'b0;
    RX_BYTE = 8'h00;
    n = 0;
  end
  // ==========================================
  // Reply capture
  always @(posedge MCLK) begin
    if (TX_VALID && n < 9) begin
      rep[n] <= TX_BYTE;
      n <= n + 1;
    end
  end
  // ==========================================
  // Frame sender, value most significant first
  task send(input [7:0] a, input [7:0] c, input [7:0] t, input [7:0] b,
    input [31:0] v, input bad);
    begin
      f[0] = a;
      f[1] = c;
      f[2] = t;
      f[3] = b;
      f[4] = v[31:24];
      f[5] = v[23:16];
      f[6] = v[15:8];
      f[7] = v[7:0];
      f[8] = {7'h00, bad};
      for (i = 0; i < 8; i = i + 1) f[8] = f[8] + f[i];
      n = 0;
      @(posedge MCLK);
      while (!RX_READY) @(posedge MCLK);
      for (i = 0; i < 9; i = i + 1) begin
        RX_VALID <= 1'b1;
        RX_BYTE <= f[i];
        @(posedge MCLK);
      end
      RX_VALID <= 1'b0;
      RX_BYTE <= ~f[8];
    end
  endtask
endmodule

// ===== sim/aice_exec_test.sv
/* Self-checking bench of the command executor.
   Assumes the host model and the port checker. */
`timescale 1ns/1ns
`include "aice_consts.vh"
module aice_exec_test;
  reg MCLK, RST, WR, RD;
  reg [7:0] ADDR;
  reg [31:0] WDATA, PC_IN, IRQ_REQ, pc_seen, e;
  reg [4:0] ERR_SET;
  wire RX_VALID, RX_READY, TX_VALID, PC_LOAD, IN_HANDLER, AXP_WE, GLP_WE;
  wire [7:0] RX_BYTE, TX_BYTE, AXP_INDEX, AXP_MOTOR, GLP_INDEX, GLP_BANK;
  wire [31:0] PC_VALUE, AXP_DATA, GLP_DATA, RDATA;
  integer n_fail, n_checks, n_axp, n_glp, n_pc, cyc, i, k, e_glp;
  aice_exec dut_u (.MCLK(MCLK), .RST(RST), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE),
    .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .ERR_SET(ERR_SET),
    .IRQ_REQ(IRQ_REQ), .PC_IN(PC_IN), .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE),
    .IN_HANDLER(IN_HANDLER), .AXP_WE(AXP_WE), .AXP_INDEX(AXP_INDEX), .AXP_MOTOR(AXP_MOTOR),
    .AXP_DATA(AXP_DATA), .GLP_WE(GLP_WE), .GLP_INDEX(GLP_INDEX), .GLP_BANK(GLP_BANK),
    .GLP_DATA(GLP_DATA), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA));
  aice_host host_u (.MCLK(MCLK), .RX_READY(RX_READY), .TX_VALID(TX_VALID),
    .TX_BYTE(TX_BYTE), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE));
  always #10 MCLK = ~MCLK;
  // ==========================================
  // Tasks
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task chk_word(input [31:0] g, input [31:0] x);
    begin
      n_checks = n_checks + 1;
      if (g !== x) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
    end
  endtask
  task chk_reply(input [7:0] st, input [7:0] c);
    reg [7:0] s;
    begin
      s = 8'h03 + st + c;
      chk_word(host_u.n, 32'h9);
      chk_word({host_u.rep[0], host_u.rep[1], host_u.rep[2], host_u.rep[3]},
        {`AICE_RST_HOST_ADDR, `AICE_RST_MOD_ADDR, st, c});
      chk_word({host_u.rep[4], host_u.rep[5], host_u.rep[6], host_u.rep[7]}, 32'h0);
      chk_word({24'h0, host_u.rep[8]}, {24'h0, s});
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge MCLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] x);
    begin
      @(posedge MCLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1 chk_word(RDATA, x);
    end
  endtask
  task cmd(input [7:0] c, input [7:0] t, input [7:0] b, input [31:0] v, input bad);
    begin
      host_u.send(`AICE_RST_MOD_ADDR, c, t, b, v, bad);
      i = 0;
      while (host_u.n != 9 && i < 40) begin
        @(posedge MCLK);
        i = i + 1;
      end
      @(posedge MCLK);
    end
  endtask
  // ==========================================
  // Monitors and timeout
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (AXP_WE === 1'b1) n_axp <= n_axp + 1;
    if (GLP_WE === 1'b1) n_glp <= n_glp + 1;
    if (PC_LOAD === 1'b1) begin
      n_pc <= n_pc + 1;
      pc_seen <= PC_VALUE;
    end
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  end
  // ==========================================
  // Tests
  initial begin
    MCLK = 0; RST = 1; WR = 0; RD = 0; ADDR = 0; WDATA = 0;
    PC_IN = 0; IRQ_REQ = 0; ERR_SET = 0; pc_seen = 0;
    n_fail = 0; n_checks = 0; n_axp = 0; n_glp = 0; n_pc = 0; cyc = 0; e_glp = 0;
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    rd_chk(`AICE_REG_ACCU, 32'h0);
    rd_chk(`AICE_REG_CTRL, 32'h0002_0100);
    rd_chk(8'h20, 32'h0);
    $display("test reset done");
    wr(`AICE_REG_ACCU, 32'h1234_5678);
    cmd(`AICE_CMD_ACCU_TO_AXIS, 8'h07, 8'h01, 32'h0, 0);
    chk_reply(`AICE_ST_OK, `AICE_CMD_ACCU_TO_AXIS);
    chk_word({n_axp[7:0], AXP_INDEX, AXP_MOTOR, 8'h00}, 32'h0107_0100);
    chk_word(AXP_DATA, 32'h1234_5678);
    for (k = 0; k < 4; k = k + 1) begin
      cmd(`AICE_CMD_ACCU_TO_GLOBAL, 8'h2A, k[7:0], 32'hFFFF_FFFF, 0);
      if (k != 1) e_glp = e_glp + 1;
      chk_reply(`AICE_ST_OK, `AICE_CMD_ACCU_TO_GLOBAL);
      chk_word(n_glp, e_glp);
    end
    chk_word({GLP_INDEX, GLP_BANK, 16'h0}, 32'h2A03_0000);
    chk_word(GLP_DATA, 32'h1234_5678);
    cmd(`AICE_CMD_ACCU_TO_AXIS, 8'h09, 8'h00, 32'h0, 1);
    chk_reply(`AICE_ST_BAD_SUM, `AICE_CMD_ACCU_TO_AXIS);
    chk_word(n_axp, 32'h1);
    cmd(8'h30, 8'h00, 8'h00, 32'h0, 0);
    chk_reply(`AICE_ST_BAD_CMD, 8'h30);
    $display("test transfers done");
    for (k = 1; k < 6; k = k + 1) begin
      ERR_SET <= 5'h1F;
      @(posedge MCLK);
      ERR_SET <= 5'h00;
      cmd(`AICE_CMD_CLEAR_FLAGS, k[7:0], 8'h05, 32'hFFFF_FFFF, 0);
      chk_reply(`AICE_ST_OK, `AICE_CMD_CLEAR_FLAGS);
      rd_chk(`AICE_REG_FLAGS, 32'h1F ^ (32'h1 << (k - 1)));
    end
    // Frame for another module: no execution and no reply
    host_u.send(8'h05, `AICE_CMD_CLEAR_FLAGS, 8'h00, 8'h00, 32'h0, 0);
    repeat (20) @(posedge MCLK);
    chk_word(host_u.n, 32'h0);
    rd_chk(`AICE_REG_FLAGS, 32'h0F);
    cmd(`AICE_CMD_CLEAR_FLAGS, 8'h00, 8'h05, 32'hFFFF_FFFF, 0);
    rd_chk(`AICE_REG_FLAGS, 32'h0);
    $display("test flags done");
    cmd(`AICE_CMD_IRQ_ENABLE, 8'h03, 8'h07, 32'hFFFF_FFFF, 0);
    cmd(`AICE_CMD_IRQ_ENABLE, 8'h1F, 8'h00, 32'h0, 0);
    rd_chk(`AICE_REG_IRQ_EN, 32'h8000_0008);
    cmd(`AICE_CMD_IRQ_DISABLE, 8'h1F, 8'h07, 32'hFFFF_FFFF, 0);
    rd_chk(`AICE_REG_IRQ_EN, 32'h0000_0008);
    cmd(`AICE_CMD_IRQ_ENABLE, `AICE_IRQ_GLOBAL, 8'h00, 32'h0, 0);
    rd_chk(`AICE_REG_CTRL, 32'h0002_0101);
    // Vector commands stand in for a stored program's stream
    cmd(`AICE_CMD_IRQ_VECTOR, 8'h03, 8'h00, 32'h50, 0);
    wr(`AICE_REG_VSEL, 32'h3);
    rd_chk(`AICE_REG_VDATA, 32'h50);
    cmd(`AICE_CMD_IRQ_VECTOR, 8'h03, 8'h00, 32'h77, 0);
    chk_reply(`AICE_ST_OK, `AICE_CMD_IRQ_VECTOR);
    rd_chk(`AICE_REG_VDATA, 32'h77);
    $display("test enables done");
    wr(`AICE_REG_ACCU, 32'hAA);
    wr(`AICE_REG_XREG, 32'h33);
    PC_IN <= 32'h10;
    IRQ_REQ <= 32'h8;
    for (i = 0; i < 10 && n_pc == 0; i = i + 1) @(posedge MCLK);
    IRQ_REQ <= 32'h0;
    chk_word(pc_seen, 32'h77);
    chk_word({31'h0, IN_HANDLER}, 32'h1);
    wr(`AICE_REG_ACCU, 32'h55);
    wr(`AICE_REG_XREG, 32'h66);
    ERR_SET <= 5'h04;
    @(posedge MCLK);
    ERR_SET <= 5'h00;
    rd_chk(`AICE_REG_FLAGS, 32'h4);
    cmd(`AICE_CMD_IRQ_RETURN, 8'h00, 8'h00, 32'h0, 0);
    chk_word({n_pc[7:0], pc_seen[23:0]}, 32'h0200_0010);
    chk_word({31'h0, IN_HANDLER}, 32'h0);
    rd_chk(`AICE_REG_ACCU, 32'hAA);
    rd_chk(`AICE_REG_XREG, 32'h33);
    rd_chk(`AICE_REG_FLAGS, 32'h0);
    cmd(`AICE_CMD_IRQ_DISABLE, `AICE_IRQ_GLOBAL, 8'h00, 32'h0, 0);
    rd_chk(`AICE_REG_CTRL, 32'h0002_0100);
    IRQ_REQ <= 32'h8;
    repeat (6) @(posedge MCLK);
    IRQ_REQ <= 32'h0;
    chk_word(n_pc, 32'h2);
    $display("test interrupts done");
    end_of_test;
  end
endmodule
